// *** src/iloagu_pkg.sv ***
// constants and types for the data-memory address generator
package iloagu_pkg;

  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned BANK_W     = 4;
  localparam int unsigned FILE_W     = 8;
  localparam int unsigned AVS_AW     = 6;
  localparam int unsigned AVS_DW     = 32;

  // opcode field positions
  localparam int unsigned FILE_LSB   = 0;
  localparam int unsigned DEST_BIT   = 8;
  localparam int unsigned ACCESS_BIT = 9;

  // indexed window upper limit and access-bank split
  localparam logic [7:0] INDEX_MAX   = 8'h5f;
  localparam logic [7:0] ACC_HI_BASE = 8'h80;
  localparam logic [3:0] BANK_LOW    = 4'h0;
  localparam logic [3:0] BANK_HIGH   = 4'hf;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_BANK    = 6'h04;
  localparam logic [5:0] OFS_PTR0    = 6'h08;
  localparam logic [5:0] OFS_PTR1    = 6'h0c;
  localparam logic [5:0] OFS_PTR2    = 6'h10;
  localparam logic [5:0] OFS_STATUS  = 6'h14;

  // reset values
  localparam logic       RST_EXT     = 1'b0;
  localparam logic [3:0] RST_BANK    = 4'h0;
  localparam logic [11:0] RST_PTR    = 12'h000;

  // extended opcodes enabled on top of the core set
  localparam int unsigned EXT_OP_COUNT = 8;

  typedef enum logic [1:0] {
    KIND_INHERENT,
    KIND_FILE,
    KIND_INDIRECT
  } iloagu_kind_t;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_INDEXED,
    MODE_FORCED,
    MODE_LONG,
    MODE_INDIRECT
  } iloagu_mode_t;

endpackage

// *** src/iloagu_top.sv ***
// data-memory address generator with indexed literal offset mode
// What this block does
// [R1] extended addressing applies only while the extended-set enable bit is 1.
// [R2] indexed mode needs the access bit 0 and a file field of at most 5Fh with extension on.
// [R3] indexed mode adds the file field to pointer two to reach any data address.
// [R4] access bit 0 with a field of 60h or more maps into access RAM 060h-07Fh and F80h-FFFh.
// [R5] access bit 1 uses direct-long addressing with the bank select register.
// [R6] instructions outside indexed mode resolve exactly as in the core set.
// [R7] inherent and literal instructions never get an offset-based address.
// [R8] indirect addressing through pointers zero and one is unchanged by the extension.
// [R9] memory size, register map and linear addressing stay the same either way.
// [R10] in indexed mode access locations 00h-5Fh form a window from pointer two to pointer two+95.
// [R11] access locations above 5Fh keep their normal mapping with extension on.
// [R12] window remapping affects indexed mode only, banked accesses stay direct.
// [R13] extension on makes eight extra opcodes available to the decoder.
// [R14] the file field is opcode bits 7:0, destination bit 8, access bit 9.
// [R15] direct-long forms a 12-bit address from the bank select register and the file field.
// [R16] each pointer holds 12 bits loaded from bits 11:0 of one bus write, upper write bits dropped.
// [R17] pointer two plus offset is truncated to 12 bits and wraps.
`timescale 1ns/1ps
`default_nettype none

module iloagu_top #(
  parameter int unsigned EXT_OPS = iloagu_pkg::EXT_OP_COUNT
) (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           ce,
  input  wire logic [iloagu_pkg::AVS_AW-1:0]  avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [iloagu_pkg::AVS_DW-1:0]  avs_writedata,
  output logic      [iloagu_pkg::AVS_DW-1:0]  avs_readdata,
  output logic                                avs_waitrequest,
  input  wire logic                           req_valid,
  input  wire logic [1:0]                     req_kind,
  input  wire logic [15:0]                    req_opcode,
  input  wire logic [1:0]                     req_ptr_sel,
  output logic      [iloagu_pkg::ADDR_W-1:0]  mem_addr,
  output logic                                mem_addr_valid,
  output logic      [2:0]                     mem_mode,
  output logic                                mem_dest_file,
  output logic                                ext_ops_enable,
  output logic      [7:0]                     ext_ops_count
);

  typedef logic [iloagu_pkg::ADDR_W-1:0] iloagu_addr_t;

  // resolve a file-field access; indexed mode only with extension on
  function automatic logic [2:0] file_mode(input logic ext, input logic acc,
                                           input logic [7:0] f);
    if (acc)
      file_mode = 3'(iloagu_pkg::MODE_LONG); // R5
    else if (ext && f <= iloagu_pkg::INDEX_MAX)
      file_mode = 3'(iloagu_pkg::MODE_INDEXED); // R1
    else
      file_mode = 3'(iloagu_pkg::MODE_FORCED); // R6
  endfunction

  // access-bank mapping: low half in bank 0, high half in bank 15
  function automatic iloagu_addr_t access_map(input logic [7:0] f);
    if (f >= iloagu_pkg::ACC_HI_BASE)
      access_map = {iloagu_pkg::BANK_HIGH, f}; // R4
    else
      access_map = {iloagu_pkg::BANK_LOW, f}; // R11
  endfunction

  // ------------------------------------------------------------ registers
  logic         ext_q,   ext_d;
  logic [3:0]   bank_q,  bank_d;
  iloagu_addr_t ptr0_q,  ptr0_d;
  iloagu_addr_t ptr1_q,  ptr1_d;
  iloagu_addr_t ptr2_q,  ptr2_d;
  logic         ack_q,   ack_d;
  logic [31:0]  rdata_q, rdata_d;
  logic         acc_req;

  assign acc_req         = avs_read | avs_write;
  assign avs_waitrequest = acc_req & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_comb
  begin
    ext_d   = ext_q;
    bank_d  = bank_q;
    ptr0_d  = ptr0_q;
    ptr1_d  = ptr1_q;
    ptr2_d  = ptr2_q;
    ack_d   = acc_req & ~ack_q;
    rdata_d = rdata_q;
    if (acc_req && !ack_q)
    begin
      rdata_d = 32'h0000_0000;
      if (avs_address == iloagu_pkg::OFS_CTRL)
      begin
        if (avs_write)
          ext_d = avs_writedata[0];
        rdata_d[0] = ext_q;
      end
      else if (avs_address == iloagu_pkg::OFS_BANK)
      begin
        if (avs_write)
          bank_d = avs_writedata[3:0];
        rdata_d[3:0] = bank_q;
      end
      else if (avs_address == iloagu_pkg::OFS_PTR0)
      begin
        if (avs_write)
          ptr0_d = avs_writedata[11:0]; // R16
        rdata_d[11:0] = ptr0_q;
      end
      else if (avs_address == iloagu_pkg::OFS_PTR1)
      begin
        if (avs_write)
          ptr1_d = avs_writedata[11:0]; // R16
        rdata_d[11:0] = ptr1_q;
      end
      else if (avs_address == iloagu_pkg::OFS_PTR2)
      begin
        if (avs_write)
          ptr2_d = avs_writedata[11:0]; // R16
        rdata_d[11:0] = ptr2_q;
      end
      else if (avs_address == iloagu_pkg::OFS_STATUS)
      begin
        rdata_d[11:0]  = mem_addr;
        rdata_d[14:12] = mem_mode;
        rdata_d[15]    = mem_addr_valid;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_q   <= iloagu_pkg::RST_EXT;
      bank_q  <= iloagu_pkg::RST_BANK;
      ptr0_q  <= iloagu_pkg::RST_PTR;
      ptr1_q  <= iloagu_pkg::RST_PTR;
      ptr2_q  <= iloagu_pkg::RST_PTR;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ext_q   <= ext_d;
      bank_q  <= bank_d;
      ptr0_q  <= ptr0_d;
      ptr1_q  <= ptr1_d;
      ptr2_q  <= ptr2_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------ resolver
  logic [7:0]   fld;
  logic         acc_bit;
  logic [2:0]   fmode;
  iloagu_addr_t addr_d,  addr_q;
  logic         valid_d, valid_q;
  logic [2:0]   mode_d,  mode_q;
  logic         dest_d,  dest_q;

  assign fld     = req_opcode[iloagu_pkg::FILE_LSB +: iloagu_pkg::FILE_W]; // R14
  assign acc_bit = req_opcode[iloagu_pkg::ACCESS_BIT]; // R14
  assign fmode   = file_mode(ext_q, acc_bit, fld); // R2

  always_comb
  begin
    addr_d  = addr_q;
    valid_d = 1'b0;
    mode_d  = mode_q;
    dest_d  = dest_q;
    if (req_valid)
    begin
      dest_d = 1'b0;
      if (req_kind == 2'(iloagu_pkg::KIND_FILE))
      begin
        valid_d = 1'b1;
        mode_d  = fmode;
        dest_d  = req_opcode[iloagu_pkg::DEST_BIT]; // R14
        if (fmode == 3'(iloagu_pkg::MODE_INDEXED))
          addr_d = iloagu_addr_t'(ptr2_q + iloagu_addr_t'(fld)); // R3 R10 R17
        else if (fmode == 3'(iloagu_pkg::MODE_LONG))
          addr_d = {bank_q, fld}; // R15 R12
        else
          addr_d = access_map(fld); // R4 R6
      end
      else if (req_kind == 2'(iloagu_pkg::KIND_INDIRECT))
      begin
        valid_d = 1'b1;
        mode_d  = 3'(iloagu_pkg::MODE_INDIRECT);
        // pointer contents are used whole, no banking, same with extension on
        if (req_ptr_sel == 2'd0)
          addr_d = ptr0_q; // R8
        else if (req_ptr_sel == 2'd1)
          addr_d = ptr1_q; // R8
        else
          addr_d = ptr2_q; // R9
      end
      else
      begin
        mode_d = 3'(iloagu_pkg::MODE_NONE); // R7
        addr_d = addr_q;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q  <= iloagu_pkg::RST_PTR;
      valid_q <= 1'b0;
      mode_q  <= 3'(iloagu_pkg::MODE_NONE);
      dest_q  <= 1'b0;
    end
    else if (ce)
    begin
      addr_q  <= addr_d;
      valid_q <= valid_d;
      mode_q  <= mode_d;
      dest_q  <= dest_d;
    end
  end

  assign mem_addr       = addr_q;
  assign mem_addr_valid = valid_q;
  assign mem_mode       = mode_q;
  assign mem_dest_file  = dest_q;
  assign ext_ops_enable = ext_q; // R13
  assign ext_ops_count  = ext_q ? 8'(EXT_OPS) : 8'h00; // R13

  // ------------------------------------------------------------ checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic take_file;
  assign take_file = ce && req_valid && req_kind == 2'(iloagu_pkg::KIND_FILE);

  ext_gate_a: assert property (take_file && !ext_q // R1
                               |=> mem_mode != 3'(iloagu_pkg::MODE_INDEXED))
    else $error("indexed mode used with extension off");

  index_enter_a: assert property (take_file && ext_q && !acc_bit && fld <= 8'h5f // R2
                                  |=> mem_mode == 3'(iloagu_pkg::MODE_INDEXED))
    else $error("indexed mode not entered");

  index_sum_a: assert property (take_file && ext_q && !acc_bit && fld <= 8'h5f // R3
                                |=> mem_addr == iloagu_addr_t'($past(ptr2_q)
                                                               + iloagu_addr_t'($past(fld))))
    else $error("indexed address is not pointer two plus offset");

  window_span_a: assert property (take_file && ext_q && !acc_bit && fld <= 8'h5f // R10
                                  |=> iloagu_addr_t'(mem_addr - $past(ptr2_q)) <= 12'h05f)
    else $error("indexed address outside the pointer two window");

  forced_map_a: assert property (take_file && !acc_bit && fld >= 8'h60 // R4
                                 |=> mem_addr == (($past(fld) >= 8'h80) ? {4'hf, $past(fld)}
                                                                         : {4'h0, $past(fld)}))
    else $error("access bank mapping wrong");

  access_hi_a: assert property (take_file && ext_q && !acc_bit && fld >= 8'h60 // R11
                                |=> mem_mode == 3'(iloagu_pkg::MODE_FORCED))
    else $error("high access location left its normal mapping");

  core_same_a: assert property (take_file && !ext_q && !acc_bit // R6
                                |=> mem_mode == 3'(iloagu_pkg::MODE_FORCED))
    else $error("core set access not resolved as forced access");

  long_addr_a: assert property (take_file && acc_bit // R5
                                |=> mem_mode == 3'(iloagu_pkg::MODE_LONG)
                                    && mem_addr == {$past(bank_q), $past(fld)})
    else $error("direct long address wrong");

  banked_keep_a: assert property (take_file && ext_q && acc_bit && fld <= 8'h5f // R12
                                  |=> mem_addr == {$past(bank_q), $past(fld)})
    else $error("banked access was remapped");

  dest_bit_a: assert property (take_file // R14
                               |=> mem_dest_file == $past(req_opcode[iloagu_pkg::DEST_BIT]))
    else $error("destination bit not passed on");

  inherent_quiet_a: assert property (ce && req_valid // R7
                                     && req_kind == 2'(iloagu_pkg::KIND_INHERENT)
                                     |=> !mem_addr_valid && mem_mode == 3'(iloagu_pkg::MODE_NONE))
    else $error("inherent instruction produced an address");

  indirect_ptr_a: assert property (ce && req_valid // R8
                                   && req_kind == 2'(iloagu_pkg::KIND_INDIRECT)
                                   && req_ptr_sel == 2'd1 |=> mem_addr == $past(ptr1_q))
    else $error("indirect address differs from pointer one");

  indirect_two_a: assert property (ce && req_valid // R9
                                   && req_kind == 2'(iloagu_pkg::KIND_INDIRECT)
                                   && req_ptr_sel == 2'd2 |=> mem_addr == $past(ptr2_q))
    else $error("indirect address differs from pointer two");

  ptr_load_a: assert property (ce && avs_write && !ack_q // R16
                               && avs_address == iloagu_pkg::OFS_PTR2
                               |=> ptr2_q == $past(avs_writedata[11:0]))
    else $error("pointer two did not take the low twelve bits");

  bus_answer_a: assert property (ce && acc_req && !ack_q && $stable(ce)
                                 |=> !avs_waitrequest or !acc_req)
    else $error("bus answer not within one cycle");

endmodule // iloagu_top

`default_nettype wire

// *** tb/iloagu_dec_model.sv ***
// decoder-side partner: registers each request and scrambles idle lines
`timescale 1ns/1ps
`default_nettype none

module iloagu_dec_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [1:0]  kind,
  input  wire logic [15:0] op,
  input  wire logic [1:0]  sel,
  output logic             req_valid,
  output logic      [1:0]  req_kind,
  output logic      [15:0] req_opcode,
  output logic      [1:0]  req_ptr_sel
);
  initial
  begin
    req_valid   = 1'b0;
    req_kind    = 2'h0;
    req_opcode  = 16'h0000;
    req_ptr_sel = 2'h0;
  end
  always @(posedge clk)
  begin
    req_valid <= go;
    if (go)
    begin
      req_kind    <= kind;
      req_opcode  <= op;
      req_ptr_sel <= sel;
    end
    else
    begin
      // released lines never hold the last value
      req_kind    <= ~req_kind;
      req_opcode  <= ~req_opcode;
      req_ptr_sel <= ~req_ptr_sel;
    end
  end
endmodule // iloagu_dec_model

`default_nettype wire

// *** tb/iloagu_top_tb.sv ***
// self-checking bench for the address generator
`timescale 1ns/1ps
`default_nettype none

module iloagu_top_tb;
  logic clk = 0, nrst = 0, ce = 1, avs_read = 0, avs_write = 0, go = 0, rd_seen;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, r, lf = 32'd91113;
  logic        avs_waitrequest, req_valid, mem_addr_valid, mem_dest_file, ext_ops_enable;
  logic [1:0]  req_kind, req_ptr_sel, kind = 0, sel = 0;
  logic [15:0] req_opcode, op = 0, last;
  logic [11:0] mem_addr, p_s [3];
  logic [2:0]  mem_mode;
  logic [7:0]  ext_ops_count;
  logic        ext_s = 0;
  logic [3:0]  bank_s = 0;
  logic [15:0] q [$];
  logic [7:0]  u_f [5] = '{8'h00, 8'h5f, 8'h60, 8'h7f, 8'h80};
  int n_errors = 0, check_count = 0, cyc = 0;

  iloagu_top u_dut (.clk(clk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
    .req_kind(req_kind), .req_opcode(req_opcode), .req_ptr_sel(req_ptr_sel),
    .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid), .mem_mode(mem_mode),
    .mem_dest_file(mem_dest_file), .ext_ops_enable(ext_ops_enable),
    .ext_ops_count(ext_ops_count));
  iloagu_dec_model u_dec (.clk(clk), .go(go), .kind(kind), .op(op), .sel(sel),
    .req_valid(req_valid), .req_kind(req_kind), .req_opcode(req_opcode),
    .req_ptr_sel(req_ptr_sel));

  initial forever #2.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  // expected {dest, mode, addr} from the shadow register state
  function automatic logic [15:0] expect_of(logic [1:0] k, logic [15:0] o, logic [1:0] s);
    logic [7:0] f;
    f = o[7:0];
    if (k == 2'd2) return {1'b0, 3'd4, p_s[(s == 2'd0) ? 0 : (s == 2'd1) ? 1 : 2]};
    if (ext_s && !o[9] && f <= 8'h5f) return {o[8], 3'd1, p_s[2] + {4'h0, f}};
    if (!o[9]) return {o[8], 3'd2, (f < 8'h80) ? 4'h0 : 4'hf, f};
    return {o[8], 3'd3, bank_s, f};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (w && a == iloagu_pkg::OFS_CTRL) ext_s = d[0];
    if (w && a == iloagu_pkg::OFS_BANK) bank_s = d[3:0];
    if (w && a >= iloagu_pkg::OFS_PTR0 && a <= iloagu_pkg::OFS_PTR2) p_s[(a - 8) >> 2] = d[11:0];
  endtask

  task automatic dreq(input logic [1:0] k, input logic [15:0] o, input logic [1:0] s);
    @(posedge clk);
    go <= 1;
    kind <= k;
    op <= o;
    sel <= s;
    if (k != 2'd0) q.push_back(expect_of(k, o, s));
    if (k != 2'd0) last = expect_of(k, o, s);
  endtask

  task automatic idle(input int n);
    @(posedge clk);
    go <= 0;
    repeat (n) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      finish_test();
    end
    else if (mem_addr_valid === 1'b1)
    begin
      if (q.size() == 0)
        chk(32'h0000_0001, 32'h0000_0000);
      else
        chk({mem_dest_file, mem_mode, mem_addr}, q.pop_front());
    end
  end

  initial
  begin
    p_s = '{12'h000, 12'h000, 12'h000};
    repeat (5) @(posedge clk);
    nrst <= 1;
    for (int a = 0; a < 7; a++)
    begin
      bus(0, 6'(a * 4), 32'h0000_0000);
      chk(r, 32'h0000_0000);
    end
    chk(ext_ops_count, 32'h0000_0000);
    bus(1, iloagu_pkg::OFS_PTR2, 32'hffff_ffff);
    bus(0, iloagu_pkg::OFS_PTR2, 32'h0000_0000);
    chk(r, 32'h0000_0fff);
    for (int e = 0; e < 2; e++)
    begin
      bus(1, iloagu_pkg::OFS_CTRL, 32'(e));
      bus(1, iloagu_pkg::OFS_BANK, 32'h0000_0005);
      bus(1, iloagu_pkg::OFS_PTR0, rnd());
      bus(1, iloagu_pkg::OFS_PTR1, rnd());
      bus(1, iloagu_pkg::OFS_PTR2, 32'h0000_0ff0);
      chk(ext_ops_count, e ? 32'h0000_0008 : 32'h0000_0000);
      chk(ext_ops_enable, 32'(e));
      foreach (u_f[i]) dreq(1, {6'b001001, 2'b00, u_f[i]}, 0);
      dreq(1, 16'h2710, 0);
      for (int s = 0; s < 4; s++) dreq(2, 16'h2600, 2'(s));
      for (int i = 0; i < 40; i++) dreq(2'd1 + 2'(rnd() % 2), {6'b001001, 10'(rnd())}, 2'(rnd()));
      idle(3);
      bus(0, iloagu_pkg::OFS_STATUS, 32'h0000_0000);
      chk(r[14:0], last[14:0]);
      bus(1, iloagu_pkg::OFS_PTR2, rnd());
    end
    dreq(0, 16'h2605, 0);
    idle(3);
    chk({mem_addr_valid, mem_mode}, 32'h0000_0000);
    @(posedge clk);
    ce <= 0;
    fork
      bus(0, iloagu_pkg::OFS_BANK, 32'h0000_0000);
      begin
        repeat (3) @(posedge clk);
        ce <= 1;
      end
    join
    chk(r, 32'h0000_0005);
    chk(q.size(), 32'h0000_0000);
    finish_test();
  end

endmodule // iloagu_top_tb

`default_nettype wire
